/* verilog/sram_port_defines.svh */
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// burst and lane layout
// ----------------------------------------------------------------
`define BURST_FIRST 2'h0
`define BURST_SECOND 2'h1
`define BURST_THIRD 2'h2
`define BURST_LAST 2'h3
`define LANE_BITS 9
`define HALF_LANE_BITS 4
`define HALF_LANE_ORG 8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define K_ABSENT_NS 1000
`define K_ABSENT_CYCLES ((`K_ABSENT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define GAP_W 16
`define CNT_W 11
`define DLL_RELOCK_CYCLES 11'h400
`define IMP_SETTLE_CYCLES 11'h400

`endif

/* verilog/sram_port_pkg.sv */
package sram_port_pkg;

	// command slot: a burst owns two input clock cycles
	typedef enum logic [0:0] {
		SLOT_FREE = 1'b0,
		SLOT_SECOND = 1'b1
	} slot_type;

endpackage

/* verilog/sync2.sv */
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int W = 1
) (
	input wire logic clk, // sampling clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic [W-1:0] d, // asynchronous input
	output logic [W-1:0] q // synchronised output
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage is read by the second stage only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule

`default_nettype wire

/* verilog/ddr_quad_burst_sram_port.sv */
// Contract
// - direction low, load low at K: write
// - write address held in write address register
// - four write words over next two cycles
// - writes stream back to back without gaps
// - load high at K: deselect, no operation
// - input data outside write beats ignored
// - x18: lane0 bits 0-8, lane1 9-17
// - x36: lane2 bits 18-26, lane3 27-35
// - x8: half lanes gate bits 0-3, 4-7
// - enables sampled per edge, per word
// - burst low bits wrap linearly from start
// - load low loads command; direction picks
// - clock stop holds; 1024 cycles relock
// - absent input clock resets the loop
// - impedance updates only in idle cycles
// - output clocks high at startup: single mode
// - pending bursts finish before deselect
// - direction high, load low: read, address held
// - read words on both output clock phases
// - outputs float after burst and deselect
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_defines.svh"

module ddr_quad_burst_sram_port #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 19,
	parameter int ORG = 36
) (
	input wire logic clk, // core clock, 200 MHz
	input wire logic rstn, // synchronous reset, active low
	input wire logic k_clk, // positive input clock pin
	input wire logic k_clk_n, // negative input clock pin
	input wire logic out_clk, // positive output clock pin
	input wire logic out_clk_n, // negative output clock pin
	input wire logic load_select_n, // load select, active low
	input wire logic read_select, // direction: high read, low write
	input wire logic [ADDR_W-1:0] addr, // burst start address
	input wire logic [DATA_W-1:0] dq_in, // data bus, input side
	input wire logic lane0_write_en_n, // lane 0 write enable
	input wire logic lane1_write_en_n, // lane 1 write enable
	input wire logic lane2_write_en_n, // lane 2 write enable
	input wire logic lane3_write_en_n, // lane 3 write enable
	input wire logic half_lane0_write_en_n, // half lane 0 write enable
	input wire logic half_lane1_write_en_n, // half lane 1 write enable
	output logic [DATA_W-1:0] dq_out, // data bus, output side
	output logic dq_oe_n, // data bus drive, active low
	output logic echo_clk, // echo of positive output phase
	output logic echo_clk_n, // echo of negative output phase
	output logic dll_locked, // loop locked, normal operation
	output logic deselected, // idle in deselect
	output logic imp_update, // impedance update pulse
	output logic imp_settled, // impedance settled
	output logic single_clock_mode // output timed from input clocks
);

	localparam int SYNC_W = ADDR_W + DATA_W + 12;
	localparam int DEPTH = 2 ** ADDR_W;

	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_s;
	logic k_s, kn_s, c_s, cn_s, ld_n_s, rd_s;
	logic [3:0] lane_en;
	logic [1:0] half_en;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] dq_s;
	logic k_prev_q, kn_prev_q, c_prev_q, cn_prev_q;
	logic k_rise, kn_rise, opos, oneg;

	assign pins_raw = {k_clk, k_clk_n, out_clk, out_clk_n, load_select_n, read_select,
		lane3_write_en_n, lane2_write_en_n, lane1_write_en_n, lane0_write_en_n,
		half_lane1_write_en_n, half_lane0_write_en_n, addr, dq_in};

	sync2 #(.W(SYNC_W)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.d(pins_raw),
		.q(pins_s)
	);

	// all pins share one latency, so data stays aligned with its edge
	assign {k_s, kn_s, c_s, cn_s, ld_n_s, rd_s} = pins_s[SYNC_W-1 -: 6];
	assign lane_en = ~pins_s[SYNC_W-7 -: 4];
	assign half_en = ~pins_s[SYNC_W-11 -: 2];
	assign addr_s = pins_s[ADDR_W+DATA_W-1 -: ADDR_W];
	assign dq_s = pins_s[DATA_W-1:0];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			k_prev_q <= 1'b0;
			kn_prev_q <= 1'b0;
			c_prev_q <= 1'b0;
			cn_prev_q <= 1'b0;
		end else begin
			k_prev_q <= k_s;
			kn_prev_q <= kn_s;
			c_prev_q <= c_s;
			cn_prev_q <= cn_s;
		end
	end

	logic single_q, mode_known_q;

	assign k_rise = k_s & ~k_prev_q;
	assign kn_rise = kn_s & ~kn_prev_q;
	assign opos = single_q ? k_rise : (c_s & ~c_prev_q);
	assign oneg = single_q ? kn_rise : (cn_s & ~cn_prev_q);

	// ----------------------------------------------------------------
	// single clock mode, fixed at the first input clock after reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			single_q <= 1'b0;
			mode_known_q <= 1'b0;
		end else if (k_rise && !mode_known_q) begin
			mode_known_q <= 1'b1;
			single_q <= c_s & cn_s;
		end
	end

	// ----------------------------------------------------------------
	// command slot
	// ----------------------------------------------------------------
	sram_port_pkg::slot_type slot_q;
	logic wr_armed_q, rd_arm_q, deselect_req_q;
	logic [ADDR_W-1:0] cmd_addr_q, rd_addr_q;

	// a taken command owns the next edge too, since a burst spans two cycles
	always_ff @(posedge clk) begin
		if (!rstn) begin
			slot_q <= sram_port_pkg::SLOT_FREE;
			wr_armed_q <= 1'b0;
			rd_arm_q <= 1'b0;
			deselect_req_q <= 1'b0;
			cmd_addr_q <= '0;
			rd_addr_q <= '0;
		end else if (k_rise) begin
			wr_armed_q <= 1'b0;
			rd_arm_q <= 1'b0;
			if (slot_q == sram_port_pkg::SLOT_SECOND) begin
				slot_q <= sram_port_pkg::SLOT_FREE;
			end else if (!ld_n_s) begin
				slot_q <= sram_port_pkg::SLOT_SECOND;
				deselect_req_q <= 1'b0;
				if (rd_s) begin
					rd_arm_q <= 1'b1;
					rd_addr_q <= addr_s;
				end else begin
					wr_armed_q <= 1'b1;
					cmd_addr_q <= addr_s;
				end
			end else begin
				deselect_req_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// write beats and lane masking
	// ----------------------------------------------------------------
	logic wr_active_q;
	logic [1:0] wr_beat_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic wr_do;
	logic [1:0] wr_beat_now;
	logic [ADDR_W-1:0] wr_base;
	logic [DATA_W-1:0] wr_mask;

	function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] base,
		input logic [1:0] beat);
		beat_addr = base;
		beat_addr[1:0] = 2'(base[1:0] + beat);
	endfunction

	// only the four beats of an armed write reach the array
	assign wr_do = (k_rise && wr_armed_q)
		|| (wr_active_q && k_rise && wr_beat_q == `BURST_THIRD)
		|| (wr_active_q && kn_rise && wr_beat_q[0]);
	// a write armed at one rise must not steal the last beat of the burst before it
	assign wr_beat_now = (k_rise && wr_armed_q) ? `BURST_FIRST : wr_beat_q;
	assign wr_base = (k_rise && wr_armed_q) ? cmd_addr_q : wr_addr_q;

	always_comb begin
		wr_mask = '0;
		for (int i = 0; i < DATA_W; i++) begin
			if (ORG == `HALF_LANE_ORG) begin
				wr_mask[i] = half_en[i / `HALF_LANE_BITS];
			end else begin
				wr_mask[i] = lane_en[i / `LANE_BITS];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_active_q <= 1'b0;
			wr_beat_q <= `BURST_FIRST;
			wr_addr_q <= '0;
		end else if (k_rise && wr_armed_q) begin
			wr_active_q <= 1'b1;
			wr_beat_q <= `BURST_SECOND;
			wr_addr_q <= cmd_addr_q;
		end else if (wr_active_q && k_rise && wr_beat_q == `BURST_THIRD) begin
			wr_beat_q <= `BURST_LAST;
		end else if (wr_active_q && kn_rise && wr_beat_q == `BURST_SECOND) begin
			wr_beat_q <= `BURST_THIRD;
		end else if (wr_active_q && kn_rise && wr_beat_q == `BURST_LAST) begin
			wr_active_q <= 1'b0;
			wr_beat_q <= `BURST_FIRST;
		end
	end

	// ----------------------------------------------------------------
	// storage array
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [0:DEPTH-1];

	// merge keeps masked-off bits, so an all-high word writes nothing
	always_ff @(posedge clk) begin
		if (wr_do) begin
			mem[beat_addr(wr_base, wr_beat_now)] <=
				(mem[beat_addr(wr_base, wr_beat_now)] & ~wr_mask) | (dq_s & wr_mask);
		end
	end

	// ----------------------------------------------------------------
	// read burst engine
	// ----------------------------------------------------------------
	logic rd_queued_q, rd_active_q;
	logic [1:0] rd_beat_q;
	logic [ADDR_W-1:0] rd_qbase_q, rd_base_q;
	logic rd_emit, rd_start;
	logic [DATA_W-1:0] dq_out_q;
	logic dq_oe_n_q;

	// even words go out on the negative phase, odd ones on the positive
	assign rd_emit = rd_active_q && ((!rd_beat_q[0] && oneg) || (rd_beat_q[0] && opos));
	assign rd_start = rd_queued_q && (!rd_active_q || (rd_emit && rd_beat_q == `BURST_LAST));

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_queued_q <= 1'b0;
			rd_qbase_q <= '0;
		end else if (k_rise && rd_arm_q) begin
			rd_queued_q <= 1'b1;
			rd_qbase_q <= rd_addr_q;
		end else if (rd_start) begin
			rd_queued_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_active_q <= 1'b0;
			rd_beat_q <= `BURST_FIRST;
			rd_base_q <= '0;
		end else if (rd_start) begin
			rd_active_q <= 1'b1;
			rd_beat_q <= `BURST_FIRST;
			rd_base_q <= rd_qbase_q;
		end else if (rd_emit) begin
			rd_beat_q <= 2'(rd_beat_q + 2'h1);
			if (rd_beat_q == `BURST_LAST) begin
				rd_active_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dq_out_q <= '0;
			dq_oe_n_q <= 1'b1;
		end else if (rd_emit) begin
			dq_out_q <= mem[beat_addr(rd_base_q, rd_beat_q)];
			dq_oe_n_q <= 1'b0;
		end else if ((opos || oneg) && !rd_active_q && !rd_queued_q) begin
			dq_oe_n_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// deselect status
	// ----------------------------------------------------------------
	logic deselected_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			deselected_q <= 1'b0;
		end else begin
			deselected_q <= deselect_req_q && !wr_armed_q && !wr_active_q && !rd_arm_q
				&& !rd_queued_q && !rd_active_q && dq_oe_n_q;
		end
	end

	// ----------------------------------------------------------------
	// loop lock: absence detection and restart count
	// ----------------------------------------------------------------
	logic [`GAP_W-1:0] gap_q;
	logic [`CNT_W-1:0] relock_q;
	logic dll_locked_q;
	logic k_absent;

	// a stopped clock freezes every edge-driven state, so outputs hold, except dll_locked, which drops once gap_q reaches the limit
	assign k_absent = (gap_q == `GAP_W'(`K_ABSENT_CYCLES));

	always_ff @(posedge clk) begin
		if (!rstn) begin
			gap_q <= '0;
		end else if (k_rise) begin
			gap_q <= '0;
		end else if (!k_absent) begin
			gap_q <= `GAP_W'(gap_q + `GAP_W'(1));
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dll_locked_q <= 1'b0;
			relock_q <= '0;
		end else if (k_absent && !k_rise) begin
			// the restart rise itself counts toward relock
			dll_locked_q <= 1'b0;
			relock_q <= '0;
		end else if (k_rise && !dll_locked_q) begin
			relock_q <= `CNT_W'(relock_q + `CNT_W'(1));
			if (relock_q == `DLL_RELOCK_CYCLES - `CNT_W'(1)) begin
				dll_locked_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// impedance update scheduling
	// ----------------------------------------------------------------
	logic imp_update_q, imp_settled_q;
	logic [`CNT_W-1:0] non_read_q;
	logic read_taken;

	assign read_taken = slot_q == sram_port_pkg::SLOT_FREE && !ld_n_s && rd_s;

	// updates only land at the start of a cycle that will not drive data
	always_ff @(posedge clk) begin
		if (!rstn) begin
			imp_update_q <= 1'b0;
		end else begin
			imp_update_q <= k_rise && dq_oe_n_q && !rd_active_q && !rd_queued_q
				&& !rd_arm_q && !read_taken;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			non_read_q <= '0;
			imp_settled_q <= 1'b0;
		end else if (k_rise && !read_taken && !imp_settled_q) begin
			non_read_q <= `CNT_W'(non_read_q + `CNT_W'(1));
			if (non_read_q == `IMP_SETTLE_CYCLES - `CNT_W'(1)) begin
				imp_settled_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// echo clocks and outputs
	// ----------------------------------------------------------------
	logic echo_q, echo_n_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			echo_q <= 1'b0;
			echo_n_q <= 1'b0;
		end else begin
			echo_q <= single_q ? k_s : c_s;
			echo_n_q <= single_q ? kn_s : cn_s;
		end
	end

	assign dq_out = dq_out_q;
	assign dq_oe_n = dq_oe_n_q;
	assign echo_clk = echo_q;
	assign echo_clk_n = echo_n_q;
	assign dll_locked = dll_locked_q;
	assign deselected = deselected_q;
	assign imp_update = imp_update_q;
	assign imp_settled = imp_settled_q;
	assign single_clock_mode = single_q;

endmodule

`default_nettype wire

/* verification/sram_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_port_chk (
	input wire logic clk, // core clock
	input wire logic rstn, // reset, active low
	input wire logic k_clk, // input clock pin
	input wire logic out_clk, // output clock pin
	input wire logic out_clk_n, // negative output clock pin
	input wire logic load_select_n, // load select
	input wire logic read_select, // high reads
	input wire logic dq_oe_n, // low drives
	input wire logic echo_clk, // echo clock
	input wire logic echo_clk_n, // negative echo clock
	input wire logic dll_locked, // loop locked
	input wire logic deselected, // deselect state
	input wire logic imp_update, // impedance update
	input wire logic single_clock_mode // single clock mode
);
	// ----------------
	// pin-side counts
	// ----------------
	logic k_q, ld_hi_q;
	logic [7:0] rd_age_q, gap_q;
	logic [11:0] krun_q, kall_q;
	wire logic k_rise = k_clk && !k_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk) begin
		k_q <= k_clk;
		if (!rstn) begin
			ld_hi_q <= 1'b0;
			rd_age_q <= 8'hff;
			gap_q <= 8'h00;
			krun_q <= 12'h000;
			kall_q <= 12'h000;
		end else begin
			if (k_rise) ld_hi_q <= load_select_n;
			// a read in an ignored slot also restarts the age, so the window is wide
			if (k_rise && !load_select_n && read_select) rd_age_q <= 8'h00;
			else if (rd_age_q != 8'hff) rd_age_q <= rd_age_q + 8'h01;
			if (k_rise) gap_q <= 8'h00;
			else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
			if (gap_q == 8'hc8) krun_q <= 12'h000;
			else if (k_rise && krun_q != 12'hfff) krun_q <= krun_q + 12'h001;
			if (k_rise && kall_q != 12'hfff) kall_q <= kall_q + 12'h001;
		end
	end
	a_update_idle: assert property (imp_update |-> dq_oe_n)
		else $error("impedance update while driving");
	a_float_desel: assert property (deselected |-> dq_oe_n)
		else $error("bus driven while deselected");
	a_desel_cause: assert property ($rose(deselected) |-> ld_hi_q)
		else $error("deselect without load high");
	a_drive_cause: assert property ($fell(dq_oe_n) |-> rd_age_q inside {[8'h10:8'h40]})
		else $error("bus driven without read");
	a_drive_hold: assert property ($fell(dq_oe_n) |-> !dq_oe_n [*8])
		else $error("read drive too short");
	a_echo_follow: assert property ($rose(out_clk) |-> ##[2:5] echo_clk)
		else $error("echo clock not following");
	a_echo_n_follow: assert property ($rose(out_clk_n) |-> ##[2:5] echo_clk_n)
		else $error("negative echo clock not following");
	a_mode_fixed: assert property (kall_q > 12'h001 |-> $stable(single_clock_mode))
		else $error("clock mode changed");
	a_lock_count: assert property ($rose(dll_locked) |-> krun_q == 12'h400)
		else $error("lock after wrong count");
	a_lock_drop: assert property (gap_q >= 8'hd2 |-> !dll_locked)
		else $error("lock held with clock absent");
endmodule
bind ddr_quad_burst_sram_port sram_port_chk sram_port_chk_inst (.clk, .rstn, .k_clk, .out_clk,
	.out_clk_n, .load_select_n, .read_select, .dq_oe_n, .echo_clk, .echo_clk_n, .dll_locked,
	.deselected, .imp_update, .single_clock_mode);
`default_nettype wire

/* verification/sram_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model #(
	parameter int DW = 36,
	parameter int AW = 19
) (
	input wire logic clk, // core clock
	input wire logic [DW-1:0] dq_out, // read data
	input wire logic dq_oe_n, // bus drive
	output logic k_clk, // input clock
	output logic k_clk_n, // its inverse
	output logic out_clk, // output clock
	output logic out_clk_n, // its inverse
	output logic load_select_n, // load select
	output logic read_select, // direction
	output logic [AW-1:0] addr, // address
	output logic [DW-1:0] dq_in, // write data
	output logic [3:0] lane_en_n, // lane enables
	output logic [1:0] half_en_n // half lane enables
);
	// output clocks follow the input pair until tie_hi holds both high
	logic tie_hi = 1'b0;
	initial begin
		{k_clk, out_clk, k_clk_n, out_clk_n, load_select_n, read_select} = 6'h0e;
		addr = '0;
		dq_in = '0;
		lane_en_n = 4'hf;
		half_en_n = 2'h3;
	end
	// one half period of the input clock: 16 core clocks, inputs settle 7 before the edge
	task automatic half(input logic p, input logic ld, input logic r, input logic [AW-1:0] a,
		input logic [DW-1:0] d, input logic v, input logic [3:0] e,
		output logic oe, output logic [DW-1:0] q);
		@(posedge clk);
		load_select_n <= ld;
		read_select <= r;
		addr <= a;
		dq_in <= v ? d : ~dq_in;
		lane_en_n <= e;
		half_en_n <= e[1:0];
		repeat (7) @(posedge clk);
		k_clk <= p;
		k_clk_n <= !p;
		out_clk <= tie_hi | p;
		out_clk_n <= tie_hi | !p;
		repeat (8) @(posedge clk);
		oe = dq_oe_n;
		q = dq_out;
	endtask
endmodule
`default_nettype wire

/* verification/tb_ddr_quad_burst_sram_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_quad_burst_sram_port;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic k_clk, k_clk_n, out_clk, out_clk_n, load_select_n, read_select, dq_oe_n;
	logic echo_clk, echo_clk_n, dll_locked, deselected, imp_update, imp_settled;
	logic single_clock_mode;
	logic [18:0] addr;
	logic [35:0] dq_in, dq_out;
	logic [3:0] lane_en_n;
	logic [1:0] half_en_n;
	logic [35:0] mem[int], wd[int], rx[int];
	logic [3:0] we[int];
	logic [16:0] lg = 17'h1ffff;
	logic [18:0] la = 19'h00000;
	int errors = 0;
	int samples_checked = 0;
	int h = 0;
	int kc = 0;
	always #2.5 clk = ~clk;
	sram_ctrl_model sram_ctrl_model_inst (.clk, .dq_out, .dq_oe_n, .k_clk, .k_clk_n, .out_clk,
		.out_clk_n, .load_select_n, .read_select, .addr, .dq_in, .lane_en_n, .half_en_n);
	ddr_quad_burst_sram_port ddr_quad_burst_sram_port_inst (.clk, .rstn, .k_clk, .k_clk_n,
		.out_clk, .out_clk_n, .load_select_n, .read_select, .addr, .dq_in,
		.lane0_write_en_n(lane_en_n[0]), .lane1_write_en_n(lane_en_n[1]),
		.lane2_write_en_n(lane_en_n[2]), .lane3_write_en_n(lane_en_n[3]),
		.half_lane0_write_en_n(half_en_n[0]), .half_lane1_write_en_n(half_en_n[1]),
		.dq_out, .dq_oe_n, .echo_clk, .echo_clk_n, .dll_locked, .deselected, .imp_update,
		.imp_settled, .single_clock_mode);
	task automatic cmp(input string n, input logic [35:0] e, input logic [35:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ----------------
	// half-edge stepping, h counts edges of both phases
	// ----------------
	task automatic step(input logic p, input logic ld, input logic r, input logic [18:0] a);
		logic oe;
		logic [35:0] q;
		sram_ctrl_model_inst.half(p, ld, r, a, wd.exists(h) ? wd[h] : 36'h0, wd.exists(h),
			we.exists(h) ? we[h] : 4'($urandom), oe, q);
		if (rx.exists(h)) begin
			cmp("dq_oe_n", 36'h0, 36'(oe));
			cmp("dq_out", rx[h], q);
		end else if (!rx.exists(h + 1) && !rx.exists(h + 2) && !rx.exists(h + 3)) begin
			cmp("dq_oe_n", 36'h1, 36'(oe));
		end
		h++;
	endtask
	task automatic k(input logic ld, input logic r, input logic [18:0] a);
		step(1'b1, ld, r, a);
		step(1'b0, ~ld, ~r, ~a);
		kc++;
	endtask
	// kind 0 write, 1 read, 2 deselect; neighbours never share a group since there is
	// no forwarding between a burst still in flight and the next one
	task automatic op(input int kind, input logic [18:0] a);
		logic [18:0] b;
		logic [35:0] d;
		logic [3:0] e;
		if (a[18:2] == lg) a[2] = ~a[2];
		if (kind == 0) la = a;
		for (int n = 0; n < 4; n++) begin
			b = {a[18:2], 2'(a[1:0] + n)};
			d = 36'({$urandom, $urandom});
			e = 4'($urandom);
			if (!mem.exists(b)) mem[b] = 'x;
			if (kind == 1) rx[h + 3 + n] = mem[b];
			if (kind == 0) begin
				wd[h + 2 + n] = d;
				we[h + 2 + n] = e;
				for (int i = 0; i < 4; i++) begin
					if (!e[i]) mem[b][9 * i +: 9] = d[9 * i +: 9];
				end
			end
		end
		lg = a[18:2];
		k(kind == 2, kind == 1, a);
		if (kind != 2) k(1'($urandom), 1'($urandom), 19'($urandom));
	endtask
	initial begin
		void'($urandom(32'h7501));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 200; i++) op($urandom_range(2), 19'($urandom) & 19'h4000f);
		while (kc < 1020) k(1'b1, 1'b0, 19'h0);
		cmp("dll_locked", 36'h0, 36'(dll_locked));
		repeat (8) k(1'b1, 1'b0, 19'h0);
		cmp("dll_locked", 36'h1, 36'(dll_locked));
		cmp("deselected", 36'h1, 36'(deselected));
		cmp("single_clock_mode", 36'h0, 36'(single_clock_mode));
		repeat (300) @(posedge clk);
		cmp("dll_locked", 36'h0, 36'(dll_locked));
		lg = 17'h1ffff;
		op(1, la);
		while (kc < 2060) k(1'b1, 1'b0, 19'h0);
		cmp("dll_locked", 36'h1, 36'(dll_locked));
		cmp("imp_settled", 36'h1, 36'(imp_settled));
		// second reset with the output clocks tied high selects single clock mode
		sram_ctrl_model_inst.tie_hi = 1'b1;
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		lg = 17'h1ffff;
		op(0, la);
		lg = 17'h1ffff;
		op(1, la);
		repeat (2) k(1'b1, 1'b0, 19'h0);
		cmp("single_clock_mode", 36'h1, 36'(single_clock_mode));
		stop_test();
	end
	initial begin
		repeat (75000) @(posedge clk);
		errors++;
		stop_test();
	end
endmodule
`default_nettype wire
